/* File: src/tmr_pkg.sv */
// package: register map, field positions, reset values and types of the timer block
package tmr_pkg;
  // register offsets (byte address on the plain register port)
  localparam logic [3:0] OFS_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_COUNT_HIGH     = 4'h1;
  localparam logic [3:0] OFS_COUNT_LOW      = 4'h2;
  localparam logic [3:0] OFS_MODULO_HIGH    = 4'h3;
  localparam logic [3:0] OFS_MODULO_LOW     = 4'h4;
  localparam logic [3:0] OFS_CH0_STATUS     = 4'h5;
  localparam logic [3:0] OFS_CH0_VALUE_HIGH = 4'h6;
  localparam logic [3:0] OFS_CH0_VALUE_LOW  = 4'h7;
  localparam logic [3:0] OFS_CH1_STATUS     = 4'h8;
  localparam logic [3:0] OFS_CH1_VALUE_HIGH = 4'h9;
  localparam logic [3:0] OFS_CH1_VALUE_LOW  = 4'hA;
  // timer status and control fields
  localparam int BIT_OVF_FLAG  = 7;
  localparam int BIT_OVF_IE    = 6;
  localparam int BIT_HALT      = 5;
  localparam int BIT_CNT_RESET = 4;
  localparam int PS_LSB        = 0;
  // channel status and control fields
  localparam int BIT_CH_FLAG   = 7;
  localparam int BIT_CH_IE     = 6;
  localparam int BIT_CH_MODE   = 4;
  localparam int CH_EDGE_LSB   = 2;
  // reset values
  localparam logic [7:0]  RST_STATUS   = 8'h20;
  localparam logic [15:0] RST_MODULO   = 16'hFFFF;
  localparam logic [15:0] RST_COUNT    = 16'h0000;
  localparam logic [2:0]  RST_PS       = 3'h0;
  localparam logic [2:0]  PS_UNUSED    = 3'h7;
  localparam logic [5:0]  RST_PRESCALE = 6'h00;
  localparam int          NUM_CH       = 2;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic       flag;
    logic       ie;
    logic       compare_mode;
    logic [1:0] edge_sel;
  } chan_cfg_t;
endpackage : tmr_pkg

/* File: src/timer_counter_prescaler_flags.sv */
// timer: 16-bit counter with prescaler, modulo, overflow flag and two capture/compare channels
`timescale 1ns/1ps

// How it works
// RQ1: overflow flag sets when the prescaled counter reaches the modulo value.
// RQ2: overflow flag clears by reading status with flag set, then writing 0.
// RQ3: an overflow between that read and write makes the 0 write ignored.
// RQ4: writing 1 to the overflow flag does nothing; reset clears it.
// RQ5: overflow request is flag and enable; reset clears the enable.
// RQ6: halt bit freezes the counter; reset sets halt.
// RQ7: while halted, input captures are suppressed.
// RQ8: counter reset bit clears counter and prescaler, self-clears, reads 0.
// RQ9: halt and counter reset in one write leave the counter halted at zero.
// RQ10: prescale select picks bus clock divided by 1..64; code 111 unused; reset clears.
// RQ11: reading count high byte latches the low byte for the next low read.
// RQ12: repeated high reads keep the latch; a low read releases it.
// RQ13: count registers read zero after reset and after counter reset.
// RQ14: at the modulo value the counter wraps to zero on the next tick.
// RQ15: after a modulo high write, overflow setting waits for the low write.
// RQ16: reset loads the modulo with all ones.
// RQ17: software resets the counter before writing a new modulo value.
// RQ18: capture channel flags on its selected active pin edge.
// RQ19: compare channel flags when the counter equals its compare value.
// RQ20: channel flag clears by reading its status with flag set, then writing 0.
// RQ21: a new event before the clear completes wins; writing 1 does nothing.
// RQ22: prescaler runs only from the bus clock; each channel picks capture or compare.
// RQ23: channel enable gates the channel request; reset clears the enable.
// RQ24: the 16-bit counter advances one per enabled prescaler tick.
module timer_counter_prescaler_flags (
  input  wire logic       sys_clk_i,    // bus clock, 50 MHz
  input  wire logic       sys_rst_i,    // synchronous reset, active high
  input  wire logic [3:0] addr_i,       // register address
  input  wire logic [7:0] wdata_i,      // write data
  input  wire logic       wr_i,         // write strobe
  input  wire logic       rd_i,         // read strobe
  output logic      [7:0] rdata_o,      // read data, cycle after rd_i
  input  wire logic [1:0] chan_pin_i,   // channel0_pin / channel1_pin level
  output logic      [1:0] chan_pin_o,   // channel pin drive value
  output logic      [1:0] chan_pin_oe_o, // channel pin output enable
  output logic            ovf_irq_o,    // overflow request
  output logic      [1:0] chan_irq_o    // channel requests
);

  tmr_pkg::bus_req_t req;
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  function automatic logic hit(input tmr_pkg::bus_req_t r, input logic [3:0] ofs);
    hit = (r.addr == ofs);
  endfunction : hit

  // -------------------------------------------------------------
  // control and counter state
  // -------------------------------------------------------------
  logic        ovf_flag_r;
  logic        ovf_ie_r;
  logic        halt_r;
  logic [2:0]  ps_r;
  logic [15:0] count_r;
  logic [5:0]  prescale_r;
  logic [15:0] modulo_r;
  logic        mod_pending_r;
  logic        ovf_armed_r;
  logic        low_latched_r;
  logic [7:0]  low_hold_r;
  logic        tick;
  logic        at_mod;
  logic        ovf_evt;
  logic        cnt_rst_wr;

  assign cnt_rst_wr = req.wr && hit(req, tmr_pkg::OFS_STATUS_CONTROL)
                      && req.wdata[tmr_pkg::BIT_CNT_RESET];

  // select one of seven taps of the bus-clock divider; code 111 never ticks
  always_comb begin
    case (ps_r)
      3'h0:    tick = 1'b1;
      3'h1:    tick = (prescale_r[0:0] == 1'h1);
      3'h2:    tick = (prescale_r[1:0] == 2'h3);
      3'h3:    tick = (prescale_r[2:0] == 3'h7);
      3'h4:    tick = (prescale_r[3:0] == 4'hF);
      3'h5:    tick = (prescale_r[4:0] == 5'h1F);
      3'h6:    tick = (prescale_r[5:0] == 6'h3F);
      default: tick = 1'b0;
    endcase
  end
  assign at_mod  = (count_r == modulo_r);
  assign ovf_evt = !halt_r && tick && at_mod && !mod_pending_r;

  // divider counts off the bus clock while not halted; there is no outside clock to select
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || cnt_rst_wr) begin
      prescale_r <= tmr_pkg::RST_PRESCALE; // RQ8
    end else if (!halt_r) begin
      prescale_r <= prescale_r + 6'h01; // RQ22
    end
  end

  // wrap needs equality: a count already past a new modulo runs on to FFFF first
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || cnt_rst_wr) begin
      count_r <= tmr_pkg::RST_COUNT; // RQ8 RQ9 RQ13
    end else if (!halt_r && tick) begin // RQ6
      count_r <= at_mod ? tmr_pkg::RST_COUNT : count_r + 16'h0001; // RQ14 RQ24
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ovf_ie_r <= 1'b0; // RQ5
      halt_r   <= 1'b1; // RQ6
      ps_r     <= tmr_pkg::RST_PS; // RQ10
    end else if (req.wr && hit(req, tmr_pkg::OFS_STATUS_CONTROL)) begin
      ovf_ie_r <= req.wdata[tmr_pkg::BIT_OVF_IE];
      halt_r   <= req.wdata[tmr_pkg::BIT_HALT]; // RQ9
      ps_r     <= req.wdata[tmr_pkg::PS_LSB +: 3]; // RQ10
    end
  end

  // overflow flag: set beats clear; a clear needs an armed read with no overflow since
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ovf_flag_r  <= 1'b0; // RQ4
      ovf_armed_r <= 1'b0;
    end else begin
      if (ovf_evt) begin
        ovf_flag_r  <= 1'b1; // RQ1
        ovf_armed_r <= 1'b0; // RQ3
      end else if (req.wr && hit(req, tmr_pkg::OFS_STATUS_CONTROL)) begin
        if (!req.wdata[tmr_pkg::BIT_OVF_FLAG] && ovf_armed_r) begin
          ovf_flag_r <= 1'b0; // RQ2 RQ4
        end
        ovf_armed_r <= 1'b0;
      end else if (req.rd && hit(req, tmr_pkg::OFS_STATUS_CONTROL) && ovf_flag_r) begin
        ovf_armed_r <= 1'b1; // RQ2
      end
    end
  end

  // modulo: high write suppresses overflow until the low byte lands
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      modulo_r      <= tmr_pkg::RST_MODULO; // RQ16
      mod_pending_r <= 1'b0;
    end else if (req.wr && hit(req, tmr_pkg::OFS_MODULO_HIGH)) begin
      modulo_r[15:8] <= req.wdata;
      mod_pending_r  <= 1'b1; // RQ15
    end else if (req.wr && hit(req, tmr_pkg::OFS_MODULO_LOW)) begin
      modulo_r[7:0]  <= req.wdata;
      mod_pending_r  <= 1'b0; // RQ15
    end
  end

  // low byte latch on high read; further high reads keep the first snapshot
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || cnt_rst_wr) begin
      low_latched_r <= 1'b0; // RQ13
      low_hold_r    <= 8'h00;
    end else if (req.rd && hit(req, tmr_pkg::OFS_COUNT_HIGH) && !low_latched_r) begin
      low_latched_r <= 1'b1; // RQ11
      low_hold_r    <= count_r[7:0];
    end else if (req.rd && hit(req, tmr_pkg::OFS_COUNT_LOW)) begin
      low_latched_r <= 1'b0; // RQ12
    end
  end

  // -------------------------------------------------------------
  // channels
  // -------------------------------------------------------------
  tmr_pkg::chan_cfg_t cfg_r [tmr_pkg::NUM_CH];
  logic [15:0]        chval_r [tmr_pkg::NUM_CH];
  logic [tmr_pkg::NUM_CH-1:0] pin_s1_r;
  logic [tmr_pkg::NUM_CH-1:0] pin_s2_r;
  logic [tmr_pkg::NUM_CH-1:0] pin_s3_r;
  logic [tmr_pkg::NUM_CH-1:0] pin_lvl_r;
  logic [tmr_pkg::NUM_CH-1:0] ch_armed_r;
  logic [tmr_pkg::NUM_CH-1:0] ch_evt;
  logic [tmr_pkg::NUM_CH-1:0] pin_drv_r;

  // three-stage synchroniser; a level counts when stages two and three agree
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pin_s1_r  <= 2'h0;
      pin_s2_r  <= 2'h0;
      pin_s3_r  <= 2'h0;
      pin_lvl_r <= 2'h0;
    end else begin
      pin_s1_r <= chan_pin_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_lvl_r <= (pin_s2_r & pin_s3_r) | (pin_lvl_r & (pin_s2_r | pin_s3_r));
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < tmr_pkg::NUM_CH; gi++) begin : g_ch
      logic [3:0] ofs_st;
      logic [3:0] ofs_hi;
      logic [3:0] ofs_lo;
      logic       rise;
      logic       fall;
      logic       new_lvl;
      assign ofs_st = (gi == 0) ? tmr_pkg::OFS_CH0_STATUS : tmr_pkg::OFS_CH1_STATUS;
      assign ofs_hi = (gi == 0) ? tmr_pkg::OFS_CH0_VALUE_HIGH : tmr_pkg::OFS_CH1_VALUE_HIGH;
      assign ofs_lo = (gi == 0) ? tmr_pkg::OFS_CH0_VALUE_LOW : tmr_pkg::OFS_CH1_VALUE_LOW;
      assign new_lvl = (pin_s2_r[gi] == pin_s3_r[gi]) ? pin_s2_r[gi] : pin_lvl_r[gi];
      assign rise = new_lvl && !pin_lvl_r[gi];
      assign fall = !new_lvl && pin_lvl_r[gi];

      always_comb begin
        if (cfg_r[gi].compare_mode) begin
          ch_evt[gi] = !halt_r && tick && (count_r == chval_r[gi]); // RQ19
        end else begin
          ch_evt[gi] = !halt_r // RQ7
                       && ((cfg_r[gi].edge_sel[0] && rise)
                        || (cfg_r[gi].edge_sel[1] && fall)); // RQ18
        end
      end

      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          cfg_r[gi]      <= '0; // RQ21 RQ23
          ch_armed_r[gi] <= 1'b0;
        end else begin
          if (req.wr && hit(req, ofs_st)) begin
            cfg_r[gi].ie           <= req.wdata[tmr_pkg::BIT_CH_IE]; // RQ23
            cfg_r[gi].compare_mode <= req.wdata[tmr_pkg::BIT_CH_MODE]; // RQ22
            cfg_r[gi].edge_sel     <= req.wdata[tmr_pkg::CH_EDGE_LSB +: 2];
          end
          if (ch_evt[gi]) begin
            cfg_r[gi].flag <= 1'b1; // RQ18 RQ19 RQ21
            ch_armed_r[gi] <= 1'b0;
          end else if (req.wr && hit(req, ofs_st)) begin
            if (!req.wdata[tmr_pkg::BIT_CH_FLAG] && ch_armed_r[gi]) begin
              cfg_r[gi].flag <= 1'b0; // RQ20
            end
            ch_armed_r[gi] <= 1'b0;
          end else if (req.rd && hit(req, ofs_st) && cfg_r[gi].flag) begin
            ch_armed_r[gi] <= 1'b1; // RQ20
          end
        end
      end

      // capture value or compare value; compare toggles the pin on match
      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          chval_r[gi]   <= 16'h0000;
          pin_drv_r[gi] <= 1'b0;
        end else begin
          if (ch_evt[gi] && !cfg_r[gi].compare_mode) begin
            chval_r[gi] <= count_r;
          end else if (req.wr && hit(req, ofs_hi)) begin
            chval_r[gi][15:8] <= req.wdata;
          end else if (req.wr && hit(req, ofs_lo)) begin
            chval_r[gi][7:0] <= req.wdata;
          end
          if (ch_evt[gi] && cfg_r[gi].compare_mode) begin
            pin_drv_r[gi] <= !pin_drv_r[gi];
          end
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------
  // outputs and read port
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ovf_irq_o     <= 1'b0;
      chan_irq_o    <= 2'h0;
      chan_pin_o    <= 2'h0;
      chan_pin_oe_o <= 2'h0;
    end else begin
      ovf_irq_o <= ovf_flag_r && ovf_ie_r; // RQ5
      for (int i = 0; i < tmr_pkg::NUM_CH; i++) begin
        chan_irq_o[i]    <= cfg_r[i].flag && cfg_r[i].ie; // RQ23
        chan_pin_o[i]    <= pin_drv_r[i];
        chan_pin_oe_o[i] <= cfg_r[i].compare_mode && (cfg_r[i].edge_sel != 2'h0);
      end
    end
  end

  function automatic logic [7:0] ch_status(input tmr_pkg::chan_cfg_t c);
    ch_status = {c.flag, c.ie, 1'b0, c.compare_mode, c.edge_sel, 2'h0};
  endfunction : ch_status

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        tmr_pkg::OFS_STATUS_CONTROL: rdata_o <= {ovf_flag_r, ovf_ie_r, halt_r, 1'b0,
                                                  1'b0, ps_r}; // RQ8
        tmr_pkg::OFS_COUNT_HIGH:     rdata_o <= count_r[15:8];
        tmr_pkg::OFS_COUNT_LOW:      rdata_o <= low_latched_r ? low_hold_r
                                                              : count_r[7:0]; // RQ11
        tmr_pkg::OFS_MODULO_HIGH:    rdata_o <= modulo_r[15:8];
        tmr_pkg::OFS_MODULO_LOW:     rdata_o <= modulo_r[7:0];
        tmr_pkg::OFS_CH0_STATUS:     rdata_o <= ch_status(cfg_r[0]);
        tmr_pkg::OFS_CH0_VALUE_HIGH: rdata_o <= chval_r[0][15:8];
        tmr_pkg::OFS_CH0_VALUE_LOW:  rdata_o <= chval_r[0][7:0];
        tmr_pkg::OFS_CH1_STATUS:     rdata_o <= ch_status(cfg_r[1]);
        tmr_pkg::OFS_CH1_VALUE_HIGH: rdata_o <= chval_r[1][15:8];
        tmr_pkg::OFS_CH1_VALUE_LOW:  rdata_o <= chval_r[1][7:0];
        default:                     rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  a_ovf_sets: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RQ1
    ovf_evt |=> ovf_flag_r) else $error("overflow flag not set");
  a_ovf_noclear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RQ3
    (ovf_flag_r && !ovf_armed_r) |=> ovf_flag_r) else $error("unarmed clear took effect");
  a_ovf_irq: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RQ5
    ##1 ovf_irq_o == $past(ovf_flag_r && ovf_ie_r)) else $error("overflow request wrong");
  a_halt_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RQ6
    (halt_r && !cnt_rst_wr) |=> $stable(count_r)) else $error("counter moved while halted");
  a_cnt_reset: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RQ8
    cnt_rst_wr |=> (count_r == 16'h0000 && prescale_r == 6'h00)) else $error("reset missed");
  a_wrap_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RQ14
    (!halt_r && tick && at_mod && !cnt_rst_wr) |=> count_r == 16'h0000)
    else $error("no wrap at modulo");
  a_count_step: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RQ24
    (!halt_r && tick && !at_mod && !cnt_rst_wr) |=> count_r == $past(count_r) + 16'h0001)
    else $error("counter did not advance by one");
  a_ovf_w1: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RQ4
    (ovf_flag_r && req.wr && hit(req, tmr_pkg::OFS_STATUS_CONTROL)
     && req.wdata[tmr_pkg::BIT_OVF_FLAG]) |=> ovf_flag_r) else $error("flag cleared by one");
  // watch the flag itself, so a broken pending gate is caught
  a_mod_pending: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RQ15
    (mod_pending_r && !ovf_flag_r) |=> !ovf_flag_r)
    else $error("overflow while modulo pending");
  a_latch_keep: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RQ12
    (low_latched_r && !(req.rd && hit(req, tmr_pkg::OFS_COUNT_LOW)) && !cnt_rst_wr)
    |=> $stable(low_hold_r)) else $error("latched low byte changed");
  a_unused_ps: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RQ10
    (ps_r == tmr_pkg::PS_UNUSED && !cnt_rst_wr) |=> $stable(count_r))
    else $error("unused prescale ticked");

  // -------------------------------------------------------------
  // assertions: channels
  // -------------------------------------------------------------
  a_cap_halt: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RQ7
    (halt_r && !cfg_r[0].compare_mode && !cfg_r[0].flag) |=> !cfg_r[0].flag)
    else $error("capture while halted");
  a_ch_noclear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RQ21
    (cfg_r[0].flag && !ch_armed_r[0]) |=> cfg_r[0].flag) else $error("unarmed channel clear");
  a_ch_w1: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RQ21
    (cfg_r[0].flag && req.wr && hit(req, tmr_pkg::OFS_CH0_STATUS)
     && req.wdata[tmr_pkg::BIT_CH_FLAG]) |=> cfg_r[0].flag)
    else $error("channel flag cleared by one");
  a_ch_irq: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RQ23
    ##1 chan_irq_o[0] == $past(cfg_r[0].flag && cfg_r[0].ie))
    else $error("channel request wrong");
  a_ch_flag_set: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RQ19
    ch_evt[1] |=> cfg_r[1].flag) else $error("channel event lost");

  // -------------------------------------------------------------
  // coverage of the main scenarios
  // -------------------------------------------------------------
  c_overflow: cover property (@(posedge sys_clk_i) ovf_evt);
  c_ovf_clear: cover property (@(posedge sys_clk_i) ovf_flag_r ##1 !ovf_flag_r);
  c_capture: cover property (@(posedge sys_clk_i) ch_evt[0] && !cfg_r[0].compare_mode);
  c_compare: cover property (@(posedge sys_clk_i) ch_evt[1] && cfg_r[1].compare_mode);
  c_latch: cover property (@(posedge sys_clk_i) low_latched_r ##1 !low_latched_r);

endmodule : timer_counter_prescaler_flags

/* File: test/timer_counter_prescaler_flags_test.sv */
// testbench: timer counter with prescaler, overflow flag and capture/compare channels
`timescale 1ns/1ps
module timer_counter_prescaler_flags_test;
  logic       sys_clk_i;
  logic       sys_rst_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic [1:0] chan_pin_i;
  logic [1:0] chan_pin_o;
  logic [1:0] chan_pin_oe_o;
  logic       ovf_irq_o;
  logic [1:0] chan_irq_o;
  int         err_total;
  int         n_compared;
  logic [7:0] d;
  logic [7:0] h;
  logic [7:0] l;
  int         cv;

  timer_counter_prescaler_flags timer_counter_prescaler_flags_inst (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .chan_pin_i(chan_pin_i),
    .chan_pin_o(chan_pin_o), .chan_pin_oe_o(chan_pin_oe_o), .ovf_irq_o(ovf_irq_o),
    .chan_irq_o(chan_irq_o));

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------------------------------
  // bus tasks and comparisons
  // ----------------------------------------------------------------
  task automatic conclude();
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk8

  // the bus tasks around each timed span add a few cycles, so counts are judged inside a window
  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [15:0] g);
    n_compared++;
    if ($isunknown(g) || int'(g) < lo || int'(g) > hi) begin
      $display("[FAIL] %s expected %0d..%0d seen %h", nm, lo, hi, g);
      err_total++;
    end
  endtask : chk_rng

  task automatic wr(input logic [3:0] a, input logic [7:0] w);
    @(posedge sys_clk_i);
    addr_i  <= a;
    wdata_i <= w;
    wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i   <= 1'b0;
    #1;
    q = rdata_o;
  endtask : rd

  // polling reads the status with the flag set, which also arms the clear
  task automatic wait_bit(input logic [3:0] a, input int b, input int lim);
    logic [7:0] q;
    bit         seen;
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      rd(a, q);
      seen = (q[b] === 1'b1);
    end
    chk8("flag wait", 8'h01, {7'h00, seen});
  endtask : wait_bit

  task automatic pin0(input logic v);
    @(posedge sys_clk_i);
    chan_pin_i[0] <= v;
    repeat (8) @(posedge sys_clk_i);
  endtask : pin0

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_total++;
    conclude();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    err_total = 0;
    n_compared = 0;
    sys_rst_i = 1'b1;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    chan_pin_i = 2'h0;
    void'($urandom(81));
    repeat (4) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    rd(tmr_pkg::OFS_STATUS_CONTROL, d); chk8("status rst", tmr_pkg::RST_STATUS, d);
    rd(tmr_pkg::OFS_MODULO_HIGH, d); chk8("mod hi rst", 8'hFF, d);
    rd(tmr_pkg::OFS_MODULO_LOW, d); chk8("mod lo rst", 8'hFF, d);
    wr(tmr_pkg::OFS_COUNT_HIGH, 8'h55);
    rd(tmr_pkg::OFS_COUNT_HIGH, d); chk8("count hi rst", 8'h00, d);
    rd(tmr_pkg::OFS_COUNT_LOW, d); chk8("count lo rst", 8'h00, d);
    for (int a = 11; a < 16; a++) begin
      rd(a[3:0], d); chk8("unmapped", 8'h00, d);
    end
    // each divide code: count over a fixed span, halted at the end
    for (int ps = 0; ps < 7; ps++) begin
      wr(tmr_pkg::OFS_STATUS_CONTROL, 8'h30 | ps[7:0]);
      rd(tmr_pkg::OFS_COUNT_HIGH, h); chk8("count hi clr", 8'h00, h);
      rd(tmr_pkg::OFS_COUNT_LOW, l); chk8("count lo clr", 8'h00, l);
      wr(tmr_pkg::OFS_STATUS_CONTROL, ps[7:0]);
      repeat (512) @(posedge sys_clk_i);
      wr(tmr_pkg::OFS_STATUS_CONTROL, 8'h20 | ps[7:0]);
      rd(tmr_pkg::OFS_STATUS_CONTROL, d); chk8("status ps", 8'h20 | ps[7:0], d);
      rd(tmr_pkg::OFS_COUNT_HIGH, h);
      rd(tmr_pkg::OFS_COUNT_LOW, l);
      chk_rng("count ps", (512 >> ps) - 1, (512 >> ps) + 3, {h, l});
      repeat (20) @(posedge sys_clk_i);
      rd(tmr_pkg::OFS_COUNT_LOW, d); chk8("count halted", l, d);
    end
    // low byte latch while the counter runs slowly
    wr(tmr_pkg::OFS_STATUS_CONTROL, 8'h36);
    wr(tmr_pkg::OFS_STATUS_CONTROL, 8'h06);
    rd(tmr_pkg::OFS_COUNT_HIGH, h);
    repeat (300) @(posedge sys_clk_i);
    rd(tmr_pkg::OFS_COUNT_HIGH, h); chk8("count hi run", 8'h00, h);
    rd(tmr_pkg::OFS_COUNT_LOW, l); chk_rng("latched lo", 0, 1, {8'h00, l});
    rd(tmr_pkg::OFS_COUNT_LOW, l); chk_rng("live lo", 4, 6, {8'h00, l});
    // modulo high write holds off the flag until the low write
    wr(tmr_pkg::OFS_STATUS_CONTROL, 8'h30);
    wr(tmr_pkg::OFS_MODULO_HIGH, 8'h00);
    wr(tmr_pkg::OFS_STATUS_CONTROL, 8'h00);
    // run past the interim 00FF modulo so the hold-off is really exercised
    repeat (300) @(posedge sys_clk_i);
    rd(tmr_pkg::OFS_STATUS_CONTROL, d); chk8("ovf held off", 8'h00, d);
    wr(tmr_pkg::OFS_STATUS_CONTROL, 8'h10);
    wr(tmr_pkg::OFS_MODULO_LOW, 8'h10);
    wait_bit(tmr_pkg::OFS_STATUS_CONTROL, 7, 40);
    wr(tmr_pkg::OFS_STATUS_CONTROL, 8'hA0);
    rd(tmr_pkg::OFS_COUNT_HIGH, h);
    rd(tmr_pkg::OFS_COUNT_LOW, l); chk_rng("wrap", 0, 16, {h, l});
    rd(tmr_pkg::OFS_STATUS_CONTROL, d); chk8("ovf w1", 8'hA0, d);
    wr(tmr_pkg::OFS_STATUS_CONTROL, 8'h20);
    rd(tmr_pkg::OFS_STATUS_CONTROL, d); chk8("ovf clear", 8'h20, d);
    // an overflow between arming read and clearing write wins
    wr(tmr_pkg::OFS_STATUS_CONTROL, 8'h00);
    wait_bit(tmr_pkg::OFS_STATUS_CONTROL, 7, 40);
    repeat (40) @(posedge sys_clk_i);
    wr(tmr_pkg::OFS_STATUS_CONTROL, 8'h20);
    rd(tmr_pkg::OFS_STATUS_CONTROL, d); chk8("ovf kept", 8'hA0, d);
    wr(tmr_pkg::OFS_STATUS_CONTROL, 8'hE0);
    repeat (3) @(posedge sys_clk_i);
    chk8("ovf irq on", 8'h01, {7'h00, ovf_irq_o});
    rd(tmr_pkg::OFS_STATUS_CONTROL, d);
    wr(tmr_pkg::OFS_STATUS_CONTROL, 8'h60);
    repeat (3) @(posedge sys_clk_i);
    chk8("ovf irq off", 8'h00, {7'h00, ovf_irq_o});
    rd(tmr_pkg::OFS_STATUS_CONTROL, d); chk8("ovf clear ie", 8'h60, d);
    // channel 0 capture on rising edge, interrupt enabled
    wr(tmr_pkg::OFS_CH0_STATUS, 8'h44);
    pin0(1'b1);
    rd(tmr_pkg::OFS_CH0_STATUS, d); chk8("capture halted", 8'h44, d);
    pin0(1'b0);
    wr(tmr_pkg::OFS_STATUS_CONTROL, 8'h00);
    pin0(1'b1);
    rd(tmr_pkg::OFS_CH0_STATUS, d); chk8("capture", 8'hC4, d);
    chk8("ch irq", 8'h01, {7'h00, chan_irq_o[0]});
    chk8("ch0 oe", 8'h00, {7'h00, chan_pin_oe_o[0]});
    wr(tmr_pkg::OFS_CH0_STATUS, 8'h44);
    rd(tmr_pkg::OFS_CH0_STATUS, d); chk8("ch clear", 8'h44, d);
    pin0(1'b0);
    pin0(1'b1);
    rd(tmr_pkg::OFS_CH0_STATUS, d);
    pin0(1'b0);
    pin0(1'b1);
    wr(tmr_pkg::OFS_CH0_STATUS, 8'h44);
    rd(tmr_pkg::OFS_CH0_STATUS, d); chk8("ch kept", 8'hC4, d);
    wr(tmr_pkg::OFS_CH0_STATUS, 8'hC4);
    rd(tmr_pkg::OFS_CH0_STATUS, d); chk8("ch w1", 8'hC4, d);
    wr(tmr_pkg::OFS_CH0_STATUS, 8'h04);
    repeat (2) @(posedge sys_clk_i);
    chk8("ch irq off", 8'h00, {7'h00, chan_irq_o[0]});
    // channel 1 compare, toggle on match, at a random count below the modulo
    cv = $urandom_range(14, 1);
    wr(tmr_pkg::OFS_CH1_VALUE_HIGH, 8'h00);
    wr(tmr_pkg::OFS_CH1_VALUE_LOW, cv[7:0]);
    wr(tmr_pkg::OFS_CH1_STATUS, 8'h14);
    wait_bit(tmr_pkg::OFS_CH1_STATUS, 7, 40);
    chk8("ch1 oe", 8'h01, {7'h00, chan_pin_oe_o[1]});
    chk8("ch1 irq", 8'h00, {7'h00, chan_irq_o[1]});
    chk8("ch1 pin", 8'h01, {7'h00, chan_pin_o[1]});
    conclude();
  end
endmodule : timer_counter_prescaler_flags_test
